// File: dv/rwsc_core_model.sv
// Behavioural processor core that issues the firmware I/O writes
`timescale 1ns/1ps
module rwsc_core_model (
	input wire logic i_core_clk, // Core clock
	input wire logic i_core_hold, // Core held from executing
	input wire logic i_busrst_irq_pend, // Bus-reset interrupt pending
	output logic o_io_wr, // I/O write strobe
	output logic [7:0] o_io_addr, // I/O address
	output logic [7:0] o_io_wdata, // I/O write data
	output logic o_gie_busrst_en, // Bus-reset enable bit
	output logic o_irq_enabled, // Interrupts enabled by instruction
	output logic o_busrst_irq_ack // Bus-reset interrupt taken
);
	// Idle bus at start
	initial begin
		o_io_wr = 1'b0;
		o_io_addr = 8'h00;
		o_io_wdata = 8'h00;
		o_gie_busrst_en = 1'b0;
		o_irq_enabled = 1'b0;
		o_busrst_irq_ack = 1'b0;
	end
	// One-cycle write; a released bus shows the inverse, not the old value
	task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge i_core_clk);
		o_io_addr = addr;
		o_io_wdata = data;
		o_io_wr = 1'b1;
		@(negedge i_core_clk);
		o_io_wr = 1'b0;
		o_io_addr = ~addr;
		o_io_wdata = ~data;
	endtask
	// Enable bit set, then the interrupt-enable instruction
	task automatic irq_on();
		@(negedge i_core_clk);
		o_gie_busrst_en = 1'b1;
		o_irq_enabled = 1'b1;
	endtask
	// Take a pending bus-reset interrupt only when both enables are up
	always @(negedge i_core_clk) begin
		o_busrst_irq_ack <= o_gie_busrst_en && o_irq_enabled && !i_core_hold
			&& (i_busrst_irq_pend === 1'b1) && !o_busrst_irq_ack;
	end
endmodule

// File: dv/rwsc_top_tb_top.sv
// Self-checking testbench for the reset, watchdog and suspend sequencer
`timescale 1ns/1ps
module rwsc_top_tb_top;
	localparam int WDT = 50;
	localparam int NOI = 10;
	localparam int BYP = 20;
	localparam int HLD = 10;
	localparam int WAK = 5;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_supply_loss = 1'b0;
	logic i_osc_stable = 1'b1;
	logic i_usb_bus_reset = 1'b0;
	logic i_usb_activity = 1'b0;
	logic i_gpio_wake = 1'b0;
	logic io_wr, gie_en, irq_en, irq_ack;
	logic [7:0] io_addr, io_wdata, status, stk;
	logic hold, blk, rst_pulse, osc_en, tmr_en, pend, irq_blk;
	logic [13:0] fetch;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int n_rs = 0;
	// Clock
	always #20 i_core_clk = ~i_core_clk;
	rwsc_top #(.WDT_TIMEOUT(WDT), .NOINT_CYCLES(NOI), .BYPASS_CYCLES(BYP),
		.WDR_HOLD_CYCLES(HLD), .WAKE_CYCLES(WAK)) u_rwsc_top (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_supply_loss(i_supply_loss),
		.i_osc_stable(i_osc_stable), .i_usb_bus_reset(i_usb_bus_reset),
		.i_usb_activity(i_usb_activity), .i_gpio_wake(i_gpio_wake), .i_io_wr(io_wr),
		.i_io_addr(io_addr), .i_io_wdata(io_wdata), .i_gie_busrst_en(gie_en),
		.i_irq_enabled(irq_en), .i_busrst_irq_ack(irq_ack), .o_status_ctrl(status),
		.o_core_hold(hold), .o_block_reset(blk), .o_fetch_restart(rst_pulse),
		.o_fetch_addr(fetch), .o_stack_ptr_rst(stk), .o_osc_en(osc_en),
		.o_timer_en(tmr_en), .o_busrst_irq_pend(pend), .o_irq_block(irq_blk));
	rwsc_core_model u_rwsc_core_model (
		.i_core_clk(i_core_clk), .i_core_hold(hold), .i_busrst_irq_pend(pend),
		.o_io_wr(io_wr), .o_io_addr(io_addr), .o_io_wdata(io_wdata),
		.o_gie_busrst_en(gie_en), .o_irq_enabled(irq_en), .o_busrst_irq_ack(irq_ack));
	// Verdict and end of run
	task automatic results();
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Compare and report
	task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Restart pulses counted as they rise, apart from the bench's falling edges
	always @(posedge rst_pulse) begin
		n_rs++;
	end
	// Hang cut short
	always @(negedge i_core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			results();
		end
	end
	// Cycles until the core is let go
	task automatic count_hold(output int n);
		n = 0;
		while (hold !== 1'b0 && n < 500) begin
			@(negedge i_core_clk);
			n++;
		end
	endtask
	// Reset state, then the full start-up
	task automatic t_startup();
		int n;
		chk("rst_outs", {status, hold, blk, osc_en, tmr_en, pend}, {8'h11, 5'b11100});
		chk("rst_vec", {fetch, stk}, 22'h0);
		i_rst_n = 1'b1;
		count_hold(n);
		chk("startup_len", n >= NOI + BYP && n <= NOI + BYP + 4, 1'b1);
		chk("startup_run", {n_rs[1:0], blk, tmr_en}, 4'b0101);
	endtask
	// Supply loss, bus reset in both start-up phases, pending interrupt
	task automatic t_bus_reset();
		int n;
		int r0;
		r0 = n_rs;
		i_supply_loss = 1'b1;
		repeat (4) @(negedge i_core_clk);
		chk("loss_state", {status, hold, osc_en, tmr_en}, {8'h11, 3'b110});
		i_supply_loss = 1'b0;
		repeat (3) @(negedge i_core_clk);
		i_usb_bus_reset = 1'b1;
		repeat (2) @(negedge i_core_clk);
		i_usb_bus_reset = 1'b0;
		repeat (2) @(negedge i_core_clk);
		chk("noint_hold", hold, 1'b1);
		repeat (NOI) @(negedge i_core_clk);
		i_usb_bus_reset = 1'b1;
		repeat (2) @(negedge i_core_clk);
		i_usb_bus_reset = 1'b0;
		count_hold(n);
		chk("bypass_cut", {n <= 1, 8'(n_rs - r0)}, {1'b1, 8'h01});
		repeat (4) @(negedge i_core_clk);
		chk("irq_pending", pend, 1'b1);
		u_rwsc_core_model.irq_on();
		repeat (4) @(negedge i_core_clk);
		chk("irq_served", pend, 1'b0);
	endtask
	// Clears keep the watchdog off, then rollover and held reset
	task automatic t_watchdog();
		int n;
		int r0;
		u_rwsc_core_model.io_write(8'hff, 8'h01);
		chk("flags_clear", status, 8'h01);
		for (int k = 0; k < 6; k++) begin
			repeat (WDT / 2) @(negedge i_core_clk);
			u_rwsc_core_model.io_write(8'h26, 8'h35 * k[7:0]);
		end
		chk("wd_cleared", {blk, status}, {1'b0, 8'h01});
		n = 0;
		while (blk !== 1'b1 && n < WDT + 10) begin
			@(negedge i_core_clk);
			n++;
		end
		chk("wd_timeout", n >= WDT - 3 && n <= WDT + 3, 1'b1);
		chk("wd_reset", {status, blk, hold}, {8'h41, 2'b11});
		chk("wd_cause", status[6] && !status[4], 1'b1);
		r0 = n_rs;
		count_hold(n);
		chk("wd_hold", n >= HLD - 1 && n <= HLD + 2, 1'b1);
		chk("wd_restart", {8'(n_rs - r0), fetch}, {8'h01, 14'h0});
		u_rwsc_core_model.io_write(8'h27, 8'h00);
		chk("unmapped_wr", status, 8'h41);
		u_rwsc_core_model.io_write(8'hff, 8'h01);
	endtask
	// Suspend entry, no early wake, wake from the given source
	task automatic t_suspend(input logic use_gpio);
		int n;
		int r0;
		u_rwsc_core_model.io_write(8'h26, 8'h00);
		r0 = n_rs;
		u_rwsc_core_model.io_write(8'hff, 8'h09);
		repeat (2) @(negedge i_core_clk);
		i_osc_stable = 1'b0;
		chk("susp_gates", {osc_en, tmr_en}, 2'b00);
		repeat (WDT + 10) @(negedge i_core_clk);
		chk("susp_stays", {osc_en, blk}, 2'b00);
		i_gpio_wake = use_gpio;
		i_usb_activity = !use_gpio;
		@(negedge i_core_clk);
		i_gpio_wake = 1'b0;
		i_usb_activity = 1'b0;
		@(negedge i_core_clk);
		chk("osc_restart", {osc_en, tmr_en}, 2'b10);
		i_osc_stable = 1'b1;
		n = 0;
		while (tmr_en !== 1'b1 && n < 50) begin
			@(negedge i_core_clk);
			n++;
		end
		chk("wake_len", n >= WAK && n <= WAK + 3, 1'b1);
		chk("wake_no_rst", {8'(n_rs - r0), irq_blk}, {8'h00, 1'b1});
		u_rwsc_core_model.io_write(8'h26, 8'h5a);
		chk("irq_release", irq_blk, 1'b0);
	endtask
	// Main sequence
	initial begin
		repeat (12) @(negedge i_core_clk);
		t_startup();
		t_bus_reset();
		t_watchdog();
		t_suspend(1'b1);
		t_suspend(1'b0);
		results();
	end
endmodule

// File: rtl/rwsc_counter.sv
// Down counter with load and enable, used for every timed phase
`timescale 1ns/1ps
module rwsc_counter (
	input wire logic i_core_clk, // Core clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_load, // Load start value
	input wire logic [31:0] i_value, // Start value
	input wire logic i_en, // Count down enable
	output logic o_zero // Count reached zero
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;

	// Next count
	always_comb begin
		cnt_nxt = cnt_r;
		if (i_load) begin
			cnt_nxt = i_value;
		end else if (i_en && cnt_r != 32'h0000_0000) begin
			cnt_nxt = cnt_r - 32'h0000_0001;
		end
	end

	// Count register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cnt_r <= 32'h0000_0000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign o_zero = (cnt_r == 32'h0000_0000);
endmodule

// File: rtl/rwsc_pkg.sv
// Package of constants for the reset, watchdog and suspend controller
package rwsc_pkg;
	// Clock rate in kHz and timing figures
	localparam int unsigned CLK_KHZ = 25000;
	localparam int unsigned T_NOINT_MS = 1;
	localparam int unsigned T_BYPASS_MS = 95;
	localparam int unsigned T_WDR_HOLD_MS = 2;
	localparam int unsigned T_WAKE_MS = 1;
	localparam int unsigned NOINT_CYC = T_NOINT_MS * CLK_KHZ;
	localparam int unsigned BYPASS_CYC = T_BYPASS_MS * CLK_KHZ;
	localparam int unsigned WDR_HOLD_CYC = T_WDR_HOLD_MS * CLK_KHZ;
	localparam int unsigned WAKE_CYC = T_WAKE_MS * CLK_KHZ;
	localparam int unsigned WDT_TIMEOUT_CYC = 100000;
	// I/O addresses
	localparam logic [7:0] ADDR_WATCHDOG_CLEAR = 8'h26;
	localparam logic [7:0] ADDR_PROC_STATUS_CTRL = 8'hff;
	// Status/control field positions
	localparam int unsigned BIT_RUN = 0;
	localparam int unsigned BIT_IRQ_SENSE = 2;
	localparam int unsigned BIT_SUSPEND = 3;
	localparam int unsigned BIT_SUPPLY_LOSS = 4;
	localparam int unsigned BIT_WDOG_FLAG = 6;
	// Reset values of the status/control register
	localparam logic [7:0] PSC_RST_SUPPLY = 8'h11;
	localparam logic [7:0] PSC_RST_WDOG = 8'h41;
	// Reset values of pointers and fetch address
	localparam logic [7:0] STACK_PTR_RST = 8'h00;
	localparam logic [13:0] FETCH_ADDR_RST = 14'h0000;
	// Bus-reset enable bit in the global interrupt enable register
	localparam int unsigned BIT_GIE_BUSRST = 0;
	// Sequencer states
	typedef enum logic [2:0] {
		RWSC_SUPPLY_LOSS,
		RWSC_NOINT,
		RWSC_BYPASS,
		RWSC_WDOG_HOLD,
		RWSC_RUN,
		RWSC_SUSPEND,
		RWSC_WAKE
	} rwsc_state_e;
endpackage

// File: rtl/rwsc_top.sv
// Reset, watchdog and suspend sequencer for the embedded processor
`timescale 1ns/1ps
module rwsc_top #(
	parameter int unsigned WDT_TIMEOUT = rwsc_pkg::WDT_TIMEOUT_CYC, // Watchdog cycles
	parameter int unsigned NOINT_CYCLES = rwsc_pkg::NOINT_CYC, // Uninterruptible phase
	parameter int unsigned BYPASS_CYCLES = rwsc_pkg::BYPASS_CYC, // Bypassable phase
	parameter int unsigned WDR_HOLD_CYCLES = rwsc_pkg::WDR_HOLD_CYC, // Watchdog reset hold
	parameter int unsigned WAKE_CYCLES = rwsc_pkg::WAKE_CYC // Wake settle time
) (
	input wire logic i_core_clk, // Core clock, 25 MHz
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_supply_loss, // Supply below threshold or oscillator unstable
	input wire logic i_osc_stable, // Oscillator reports stable
	input wire logic i_usb_bus_reset, // Upstream bus reset seen
	input wire logic i_usb_activity, // Non-idle activity on any port
	input wire logic i_gpio_wake, // Enabled GPIO interrupt event
	input wire logic i_io_wr, // Processor I/O write strobe
	input wire logic [7:0] i_io_addr, // I/O address
	input wire logic [7:0] i_io_wdata, // I/O write data
	input wire logic i_gie_busrst_en, // Bus-reset enable in global interrupt enable
	input wire logic i_irq_enabled, // Processor interrupts enabled by instruction
	input wire logic i_busrst_irq_ack, // Bus-reset interrupt taken
	output logic [7:0] o_status_ctrl, // Processor status/control read value
	output logic o_core_hold, // Core held from executing
	output logic o_block_reset, // Register/address/stack reset to peripherals
	output logic o_fetch_restart, // Load fetch address 0x0000, no push
	output logic [13:0] o_fetch_addr, // Restart fetch address
	output logic [7:0] o_stack_ptr_rst, // Reset value of both stack pointers
	output logic o_osc_en, // Oscillator and PLL enable
	output logic o_timer_en, // Free-running timer enable
	output logic o_busrst_irq_pend, // Bus-reset interrupt pending
	output logic o_irq_block // Hold off interrupt service after wake
);
	rwsc_pkg::rwsc_state_e st_r, st_nxt;
	logic [7:0] psc_r, psc_nxt;
	logic pend_r, pend_nxt;
	logic irqblk_r, irqblk_nxt;
	logic hold_r, hold_nxt;
	logic brst_r, brst_nxt;
	logic rstrt_r, rstrt_nxt;
	logic osc_r, osc_nxt;
	logic tmr_r, tmr_nxt;
	logic wdt_clr, wdt_roll, wdt_en;
	logic ph_load, ph_zero;
	logic [31:0] ph_val;
	logic psc_wr;

	// I/O write decode
	function automatic logic io_hit(input logic wr, input logic [7:0] a, input logic [7:0] t);
		io_hit = wr && (a == t);
	endfunction

	assign psc_wr = io_hit(i_io_wr, i_io_addr, rwsc_pkg::ADDR_PROC_STATUS_CTRL);
	assign wdt_clr = io_hit(i_io_wr, i_io_addr, rwsc_pkg::ADDR_WATCHDOG_CLEAR);
	assign wdt_en = (st_r == rwsc_pkg::RWSC_RUN);

	// Watchdog counter, reloaded by any clear write or while not running
	rwsc_counter u_wdt (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_load(wdt_clr || !wdt_en),
		.i_value(WDT_TIMEOUT),
		.i_en(wdt_en),
		.o_zero(wdt_roll)
	);

	// Phase counter for start-up, watchdog hold and wake
	rwsc_counter u_phase (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_load(ph_load),
		.i_value(ph_val),
		.i_en(1'b1),
		.o_zero(ph_zero)
	);

	// Sequencer next state
	always_comb begin
		st_nxt = st_r;
		ph_load = 1'b0;
		ph_val = 32'h0000_0000;
		case (st_r)
			rwsc_pkg::RWSC_SUPPLY_LOSS: begin
				if (!i_supply_loss && i_osc_stable) begin
					st_nxt = rwsc_pkg::RWSC_NOINT;
					ph_load = 1'b1;
					ph_val = NOINT_CYCLES;
				end
			end
			rwsc_pkg::RWSC_NOINT: begin
				if (ph_zero) begin
					st_nxt = rwsc_pkg::RWSC_BYPASS;
					ph_load = 1'b1;
					ph_val = BYPASS_CYCLES;
				end
			end
			rwsc_pkg::RWSC_BYPASS: begin
				if (i_usb_bus_reset || ph_zero) begin
					st_nxt = rwsc_pkg::RWSC_RUN;
				end
			end
			rwsc_pkg::RWSC_WDOG_HOLD: begin
				if (ph_zero) begin
					st_nxt = rwsc_pkg::RWSC_RUN;
				end
			end
			rwsc_pkg::RWSC_RUN: begin
				if (wdt_roll) begin
					st_nxt = rwsc_pkg::RWSC_WDOG_HOLD;
					ph_load = 1'b1;
					ph_val = WDR_HOLD_CYCLES;
				end else if (psc_wr && i_io_wdata[rwsc_pkg::BIT_SUSPEND]) begin
					st_nxt = rwsc_pkg::RWSC_SUSPEND;
				end
			end
			rwsc_pkg::RWSC_SUSPEND: begin
				if (i_gpio_wake || i_usb_activity) begin
					st_nxt = rwsc_pkg::RWSC_WAKE;
					ph_load = 1'b1;
					ph_val = WAKE_CYCLES;
				end
			end
			rwsc_pkg::RWSC_WAKE: begin
				if (!i_osc_stable) begin
					ph_load = 1'b1;
					ph_val = WAKE_CYCLES;
				end else if (ph_zero) begin
					st_nxt = rwsc_pkg::RWSC_RUN;
				end
			end
			default: begin
				st_nxt = rwsc_pkg::RWSC_SUPPLY_LOSS;
			end
		endcase
		if (i_supply_loss) begin
			st_nxt = rwsc_pkg::RWSC_SUPPLY_LOSS;
		end
		if (st_r == rwsc_pkg::RWSC_WAKE && st_nxt == rwsc_pkg::RWSC_WAKE
			&& i_osc_stable && ph_zero) begin
			st_nxt = rwsc_pkg::RWSC_RUN;
		end
	end

	// Status, pending and output next values
	always_comb begin
		psc_nxt = psc_r;
		pend_nxt = pend_r;
		irqblk_nxt = irqblk_r;
		if (psc_wr) begin
			psc_nxt[rwsc_pkg::BIT_RUN] = i_io_wdata[rwsc_pkg::BIT_RUN];
			psc_nxt[rwsc_pkg::BIT_IRQ_SENSE] = i_io_wdata[rwsc_pkg::BIT_IRQ_SENSE];
			psc_nxt[rwsc_pkg::BIT_SUSPEND] = i_io_wdata[rwsc_pkg::BIT_SUSPEND];
			if (!i_io_wdata[rwsc_pkg::BIT_SUPPLY_LOSS]) begin
				psc_nxt[rwsc_pkg::BIT_SUPPLY_LOSS] = 1'b0;
			end
			if (!i_io_wdata[rwsc_pkg::BIT_WDOG_FLAG]) begin
				psc_nxt[rwsc_pkg::BIT_WDOG_FLAG] = 1'b0;
			end
		end
		if (i_busrst_irq_ack) begin
			pend_nxt = 1'b0;
		end
		if (st_r == rwsc_pkg::RWSC_BYPASS && i_usb_bus_reset) begin
			pend_nxt = 1'b1;
		end
		if (st_r == rwsc_pkg::RWSC_WAKE && st_nxt == rwsc_pkg::RWSC_RUN) begin
			irqblk_nxt = 1'b1;
		end else if (i_io_wr || st_r != rwsc_pkg::RWSC_RUN) begin
			irqblk_nxt = irqblk_r && (st_r != rwsc_pkg::RWSC_RUN);
		end
		if (st_r == rwsc_pkg::RWSC_SUSPEND) begin
			psc_nxt[rwsc_pkg::BIT_SUSPEND] = 1'b0;
		end
		if (st_nxt == rwsc_pkg::RWSC_SUPPLY_LOSS) begin
			psc_nxt = rwsc_pkg::PSC_RST_SUPPLY;
			pend_nxt = 1'b0;
		end else if (st_r == rwsc_pkg::RWSC_RUN && wdt_roll) begin
			psc_nxt = rwsc_pkg::PSC_RST_WDOG | (psc_r & 8'h10);
			pend_nxt = 1'b0;
		end
		hold_nxt = (st_nxt != rwsc_pkg::RWSC_RUN);
		brst_nxt = (st_nxt == rwsc_pkg::RWSC_SUPPLY_LOSS) || (st_nxt == rwsc_pkg::RWSC_WDOG_HOLD)
			|| (st_nxt == rwsc_pkg::RWSC_NOINT) || (st_nxt == rwsc_pkg::RWSC_BYPASS);
		rstrt_nxt = (st_nxt == rwsc_pkg::RWSC_RUN) && (st_r != rwsc_pkg::RWSC_RUN)
			&& (st_r != rwsc_pkg::RWSC_WAKE);
		osc_nxt = (st_nxt != rwsc_pkg::RWSC_SUSPEND);
		tmr_nxt = (st_nxt == rwsc_pkg::RWSC_RUN);
	end

	// State registers
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_r <= rwsc_pkg::RWSC_SUPPLY_LOSS;
			psc_r <= rwsc_pkg::PSC_RST_SUPPLY;
			pend_r <= 1'b0;
			irqblk_r <= 1'b0;
			hold_r <= 1'b1;
			brst_r <= 1'b1;
			rstrt_r <= 1'b0;
			osc_r <= 1'b1;
			tmr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			psc_r <= psc_nxt;
			pend_r <= pend_nxt;
			irqblk_r <= irqblk_nxt;
			hold_r <= hold_nxt;
			brst_r <= brst_nxt;
			rstrt_r <= rstrt_nxt;
			osc_r <= osc_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// Outputs straight from flip-flops; fetch address and stack pointer reset are constants
	assign o_status_ctrl = psc_r;
	assign o_core_hold = hold_r;
	assign o_block_reset = brst_r;
	assign o_fetch_restart = rstrt_r;
	assign o_fetch_addr = rwsc_pkg::FETCH_ADDR_RST;
	assign o_stack_ptr_rst = rwsc_pkg::STACK_PTR_RST;
	assign o_osc_en = osc_r;
	assign o_timer_en = tmr_r;
	assign o_busrst_irq_pend = pend_r;
	assign o_irq_block = irqblk_r;

	// Assertions
	hold_supply_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_supply_loss |=> o_core_hold && o_osc_en) else $error("core not held in supply loss");
	cause_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_supply_loss |=> o_status_ctrl[4]) else $error("supply-loss flag missing");
	wdog_load_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_RUN && wdt_roll && !i_supply_loss)
		|=> (o_status_ctrl & 8'hef) == 8'h41) else $error("watchdog pattern wrong");
	wdog_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_RUN && wdt_roll && !i_supply_loss)
		|=> o_block_reset && o_core_hold) else $error("watchdog reset missing");
	abort_bypass_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_BYPASS && i_usb_bus_reset && !i_supply_loss)
		|=> !o_core_hold && o_fetch_restart && o_busrst_irq_pend) else $error("bypass abort");
	noint_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_NOINT && !i_supply_loss) |=> o_core_hold && !o_fetch_restart)
		else $error("early run");
	suspend_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_SUSPEND) |-> !o_osc_en && !o_timer_en) else $error("clock runs");
	suspend_exit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_SUSPEND && !i_gpio_wake && !i_usb_activity && !i_supply_loss)
		|=> st_r == rwsc_pkg::RWSC_SUSPEND) else $error("spurious wake");
	wdt_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(wdt_clr && wdt_en) |=> !wdt_roll) else $error("clear did not restart");
	wake_block_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_WAKE && st_nxt == rwsc_pkg::RWSC_RUN) |=> o_irq_block)
		else $error("interrupt not held after wake");
	osc_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_SUSPEND && (i_gpio_wake || i_usb_activity) && !i_supply_loss)
		|=> o_osc_en && o_core_hold) else $error("oscillator not restarted at wake");
	restart_vec_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_fetch_restart |-> o_fetch_addr == rwsc_pkg::FETCH_ADDR_RST && !o_core_hold)
		else $error("restart without fetch from zero");
	wake_norst_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_WAKE) |=> !o_fetch_restart) else $error("restart after wake");

	// Cycles spent in the uninterruptible phase, for its length check
	logic [31:0] noint_cyc_r, noint_cyc_nxt;
	always_comb begin
		noint_cyc_nxt = 32'h0000_0000;
		if (st_r == rwsc_pkg::RWSC_NOINT) begin
			noint_cyc_nxt = noint_cyc_r + 32'h0000_0001;
		end
	end

	// Phase length register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			noint_cyc_r <= 32'h0000_0000;
		end else begin
			noint_cyc_r <= noint_cyc_nxt;
		end
	end

	// Uninterruptible phase lasts its full count
	noint_len_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == rwsc_pkg::RWSC_NOINT && st_nxt == rwsc_pkg::RWSC_BYPASS)
		|-> noint_cyc_r == NOINT_CYCLES) else $error("uninterruptible phase length wrong");

	// Main scenarios
	cv_abort: cover property (@(posedge i_core_clk)
		st_r == rwsc_pkg::RWSC_BYPASS && i_usb_bus_reset);
	cv_wdog: cover property (@(posedge i_core_clk) st_r == rwsc_pkg::RWSC_WDOG_HOLD);
	cv_wake: cover property (@(posedge i_core_clk) st_r == rwsc_pkg::RWSC_WAKE);
	cv_supply: cover property (@(posedge i_core_clk)
		st_r == rwsc_pkg::RWSC_RUN && i_supply_loss);
	cv_wake_run: cover property (@(posedge i_core_clk)
		st_r == rwsc_pkg::RWSC_WAKE && st_nxt == rwsc_pkg::RWSC_RUN);
endmodule
